/* File: core/rukp_consts.vh */
`ifndef RUKP_CONSTS_VH
`define RUKP_CONSTS_VH
// Register offsets (byte addresses on the register port).
`define RUKP_OFF_USER_DATA_BASE   8'h00
`define RUKP_OFF_KERNEL_PROG_BASE 8'h04
`define RUKP_OFF_RAM_SIZE         8'h08
`define RUKP_OFF_FLASH_USER_BASE  8'h0C
// Field layout of the partition register.
`define RUKP_UDB_HI  15
`define RUKP_UDB_LO  10
`define RUKP_UDB_W   6
// Writable fields of the kernel program base and flash user base registers.
`define RUKP_KPB_HI  15
`define RUKP_KPB_LO  10
`define RUKP_FUB_HI  19
`define RUKP_FUB_LO  12
// Offset added to user segment addresses on their way to the physical map.
`define RUKP_USER_PHYS_OFF 32'h4000_0000
// Reset values.
`define RUKP_UDB_RST 6'h00
`define RUKP_KPB_RST 32'h0000_0000
`define RUKP_FUB_RST 32'h0000_0000
// Default RAM size in bytes.
`define RUKP_RAM_SIZE_DEF 32'h0000_8000
// Segment selectors from the top address bits.
`define RUKP_SEG_CACHED   3'h4
`define RUKP_SEG_UNCACHED 3'h5
// Physical region bases and sizes.
`define RUKP_PHYS_RAM_BASE   32'h0000_0000
`define RUKP_PHYS_FLASH_BASE 32'h1D00_0000
`define RUKP_FLASH_SIZE_DEF  32'h0002_0000
`endif

/* File: core/rukp_partition.v */
// Functional notes
// - Single 4 GB unified address space, unique regions.
// - CPU virtual, bus masters physical addressing.
// - Program and data split user/kernel.
// - Part of data RAM may be executable.
// - Cached and uncached kernel segments mapped.
// - User data base held in bits 15:10.
// - Bits 9:0 read zero, writes ignored.
// - Bits 31:16 read zero.
// - Reset clears partition register to zero.
`timescale 1ns/100ps
`default_nettype none
`include "rukp_consts.vh"
module rukp_partition #(
  parameter [31:0] RAM_SIZE   = `RUKP_RAM_SIZE_DEF,
  parameter [31:0] FLASH_SIZE = `RUKP_FLASH_SIZE_DEF
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  input  wire        clk_en,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Access check (same clock domain)
  input  wire [31:0] acc_addr,
  input  wire        acc_phys,
  input  wire        acc_user_mode,
  input  wire        acc_fetch,
  input  wire        acc_valid,
  // Access result
  output reg  [31:0] acc_phys_addr,
  output reg         acc_cacheable,
  output reg         acc_in_ram,
  output reg         acc_user_region,
  output reg         acc_exec_ram,
  output reg         acc_fault,
  output reg         acc_done
);
  // Only the writable upper bits of the partition are stored.
  // Software keeps the base above the kernel program base and within RAM.
  // The hardware stores whatever is written and does not check that order.
  reg [`RUKP_UDB_W-1:0] udb_q;
  reg [31:0]            kpb_q;
  reg [31:0]            fub_q;
  wire [31:0] udb_full = {16'h0000, udb_q, 10'h000};

  wire [31:0] map_phys;
  wire        map_user;
  wire        map_cached;
  wire        map_uncached;

  rukp_seg_map u_map (
    .virt_addr    (acc_addr),
    .phys_mode    (acc_phys),
    .phys_addr    (map_phys),
    .user_seg     (map_user),
    .cached_seg   (map_cached),
    .uncached_seg (map_uncached)
  );

  // Partition field; writes to the low and high bits have no effect.
  always @(posedge clk) begin
    if (rst) begin
      udb_q <= `RUKP_UDB_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `RUKP_OFF_USER_DATA_BASE) begin
        udb_q <= reg_wdata[`RUKP_UDB_HI:`RUKP_UDB_LO];
      end
    end
  end

  // Kernel program base, kept in the same 1 KB steps as the partition.
  always @(posedge clk) begin
    if (rst) begin
      kpb_q <= `RUKP_KPB_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `RUKP_OFF_KERNEL_PROG_BASE) begin
        kpb_q <= {16'h0000, reg_wdata[`RUKP_KPB_HI:`RUKP_KPB_LO], 10'h000};
      end
    end
  end

  // Flash user base, kept in 4 KB steps.
  always @(posedge clk) begin
    if (rst) begin
      fub_q <= `RUKP_FUB_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `RUKP_OFF_FLASH_USER_BASE) begin
        fub_q <= {12'h000, reg_wdata[`RUKP_FUB_HI:`RUKP_FUB_LO], 12'h000};
      end
    end
  end

  // Read mux; idle cycles and unmapped addresses give zero.
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    if (!reg_rd) begin
      rdata_d = 32'h0000_0000;
    end else if (reg_addr == `RUKP_OFF_USER_DATA_BASE) begin
      rdata_d = udb_full;
    end else if (reg_addr == `RUKP_OFF_KERNEL_PROG_BASE) begin
      rdata_d = kpb_q;
    end else if (reg_addr == `RUKP_OFF_RAM_SIZE) begin
      rdata_d = RAM_SIZE;
    end else if (reg_addr == `RUKP_OFF_FLASH_USER_BASE) begin
      rdata_d = fub_q;
    end else begin
      rdata_d = 32'h0000_0000;
    end
  end

  // Read data stand in the cycle after the strobe and only there.
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= rdata_d;
    end
  end

  // Access classification.
  wire [31:0] ram_off   = map_phys - `RUKP_PHYS_RAM_BASE;
  wire [31:0] flash_off = map_phys - `RUKP_PHYS_FLASH_BASE;
  wire in_ram   = (map_phys < RAM_SIZE);
  wire in_flash = (map_phys >= `RUKP_PHYS_FLASH_BASE) && (flash_off < FLASH_SIZE);
  wire part_on  = (udb_q != `RUKP_UDB_RST);
  wire ram_user = part_on && (ram_off >= udb_full);
  // Kernel program area of RAM spans the kernel program base up to the end of RAM, user data included.
  wire ram_exec = (kpb_q != 32'h0000_0000) && (ram_off >= kpb_q);
  wire fl_user  = (fub_q != 32'h0000_0000) && (flash_off >= fub_q);
  wire region_user = in_ram ? ram_user : (in_flash && fl_user);

  // User-mode virtual accesses may touch only the user segment and user regions.
  // Bus masters use physical addresses and are faulted here only for fetches from RAM outside the kernel program area.
  wire user_virt   = !acc_phys && acc_user_mode;
  wire seg_fault   = !map_user;
  wire ram_fault   = in_ram && !ram_user;
  wire flash_fault = in_flash && !fl_user;
  wire fault_d     = user_virt && (seg_fault || ram_fault || flash_fault);
  wire fetch_fault = acc_fetch && in_ram && !ram_exec;

  // Next values of the result flags.
  wire cacheable_d = map_cached && !map_uncached;
  wire exec_d      = in_ram && ram_exec;
  wire fault_all_d = fault_d || fetch_fault;

  // The done pulse lasts one cycle; the results below hold until the next request.
  always @(posedge clk) begin
    if (rst) begin
      acc_done <= 1'b0;
    end else if (clk_en) begin
      acc_done <= acc_valid;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      acc_phys_addr <= 32'h0000_0000;
    end else if (clk_en && acc_valid) begin
      acc_phys_addr <= map_phys;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      acc_cacheable <= 1'b0;
    end else if (clk_en && acc_valid) begin
      acc_cacheable <= cacheable_d;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      acc_in_ram <= 1'b0;
    end else if (clk_en && acc_valid) begin
      acc_in_ram <= in_ram;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      acc_user_region <= 1'b0;
    end else if (clk_en && acc_valid) begin
      acc_user_region <= region_user;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      acc_exec_ram <= 1'b0;
    end else if (clk_en && acc_valid) begin
      acc_exec_ram <= exec_d;
    end
  end

  // A fault is reported in the cycle after the request that caused it, with acc_done, and held with the results.
  always @(posedge clk) begin
    if (rst) begin
      acc_fault <= 1'b0;
    end else if (clk_en && acc_valid) begin
      acc_fault <= fault_all_d;
    end
  end
endmodule // rukp_partition
`default_nettype wire

/* File: core/rukp_seg_map.v */
`timescale 1ns/100ps
`default_nettype none
// Fixed mapping of a virtual address to a physical address and segment attributes.
module rukp_seg_map (
  // Address in
  input  wire [31:0] virt_addr,
  input  wire        phys_mode,
  // Attributes out
  output wire [31:0] phys_addr,
  output wire        user_seg,
  output wire        cached_seg,
  output wire        uncached_seg
);
`include "rukp_consts.vh"
  wire [2:0] top = virt_addr[31:29];
  assign cached_seg   = !phys_mode && (top == `RUKP_SEG_CACHED);
  assign uncached_seg = !phys_mode && (top == `RUKP_SEG_UNCACHED);
  assign user_seg     = !phys_mode && !virt_addr[31];
  // Kernel segments strip the top three bits; user space is offset by 1 GB.
  assign phys_addr = phys_mode ? virt_addr :
                     virt_addr[31] ? {3'h0, virt_addr[28:0]} :
                     virt_addr + `RUKP_USER_PHYS_OFF;
endmodule // rukp_seg_map
`default_nettype wire

/* File: verification/ram_user_kernel_partition_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module ram_user_kernel_partition_bench;
  logic        clk, rst, clk_en, reg_wr, reg_rd, acc_phys, acc_user_mode, acc_fetch, acc_valid;
  logic        acc_cacheable, acc_in_ram, acc_user_region, acc_exec_ram, acc_fault, acc_done;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, acc_addr, acc_phys_addr;
  int          err_total = 0, checks = 0;
  rukp_partition #(.RAM_SIZE(32'h0000_8000), .FLASH_SIZE(32'h0002_0000)) i_dut (
    .clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_addr(acc_addr),
    .acc_phys(acc_phys), .acc_user_mode(acc_user_mode), .acc_fetch(acc_fetch),
    .acc_valid(acc_valid), .acc_phys_addr(acc_phys_addr), .acc_cacheable(acc_cacheable),
    .acc_in_ram(acc_in_ram), .acc_user_region(acc_user_region), .acc_exec_ram(acc_exec_ram),
    .acc_fault(acc_fault), .acc_done(acc_done));
  initial begin clk = 1'b0; forever #2 clk = ~clk; end
  initial begin #20000; err_total++; wrap_up; end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin err_total++; $display("unexpected at %0t: saw %h want %h", $time, s, e); end
  endtask
  function automatic logic [31:0] fl();
    return {26'h0, acc_cacheable, acc_in_ram, acc_user_region, acc_exec_ram, acc_fault, acc_done};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0; #1 chk(reg_rdata, e);
  endtask
  task automatic acc(input logic [31:0] a, input logic p, u, f);
    @(posedge clk); acc_addr <= a; acc_phys <= p; acc_user_mode <= u; acc_fetch <= f; acc_valid <= 1'b1;
    @(posedge clk); acc_valid <= 1'b0; #1 chk(fl() & 32'h1, 32'h1);
  endtask
  task t_reset;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0000_8000);
    rd(8'h40, 32'h0);
    $display("reset test end");
  endtask
  task t_field;
    wr(8'h00, 32'h0000_FFFF); rd(8'h00, 32'h0000_FC00);
    wr(8'h00, 32'hFFFF_03FF); rd(8'h00, 32'h0);
    $display("field test end");
  endtask
  task t_map;
    acc(32'h8000_0100, 0, 0, 0); chk(fl(), 32'h31); chk(acc_phys_addr, 32'h100);
    acc(32'hA000_0200, 0, 0, 0); chk(fl(), 32'h11); chk(acc_phys_addr, 32'h200);
    acc(32'h0000_0010, 0, 0, 0); chk(acc_phys_addr, 32'h4000_0010);
    acc(32'h1D00_0004, 1, 0, 0); chk(acc_phys_addr, 32'h1D00_0004);
    $display("map test end");
  endtask
  task t_part;
    wr(8'h04, 32'h0000_0400); wr(8'h00, 32'h0000_0800);
    acc(32'h0000_07FC, 1, 0, 0); chk(fl() & 32'h18, 32'h10);
    acc(32'h0000_0800, 1, 0, 0); chk(fl() & 32'h18, 32'h18);
    acc(32'h8000_0400, 0, 0, 1); chk(fl(), 32'h35);
    acc(32'h8000_03FC, 0, 0, 1); chk(fl(), 32'h33);
    acc(32'h8000_0900, 0, 1, 0); chk(fl() & 32'h2, 32'h2);
    $display("partition test end");
  endtask
  task t_hold;
    @(posedge clk); reg_addr <= 8'h00; reg_wdata <= 32'h0000_1C00; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0; #1 chk(reg_rdata, 32'h0000_1C00);
    @(posedge clk); clk_en <= 1'b0;
    wr(8'h00, 32'h0000_FC00);
    @(posedge clk); clk_en <= 1'b1;
    rd(8'h00, 32'h0000_1C00);
    wr(8'h0C, 32'h0000_1000);
    acc(32'h1D00_1000, 1, 0, 0); chk(fl() & 32'h18, 32'h08);
    acc(32'h1D00_0FFC, 1, 0, 0); chk(fl() & 32'h18, 32'h00);
    $display("hold test end");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {rst, clk_en} = 2'b11; {reg_wr, reg_rd, acc_valid, acc_phys, acc_user_mode, acc_fetch} = 6'h00;
    reg_addr = 8'h00; reg_wdata = 32'h0; acc_addr = 32'h0;
    repeat (6) @(posedge clk); rst <= 1'b0;
    t_reset; t_field; t_map; t_part; t_hold;
    @(posedge clk); rst <= 1'b1; @(posedge clk); rst <= 1'b0;
    t_reset;
    wrap_up;
  end
endmodule // ram_user_kernel_partition_bench
`default_nettype wire

/* File: verification/rukp_partition_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module rukp_chk #(parameter [31:0] RAM_SIZE = 32'h0000_8000) (
  input wire logic        clk, rst, clk_en, reg_wr, reg_rd, acc_valid, acc_phys,
  input wire logic        acc_user_mode, acc_cacheable, acc_in_ram, acc_user_region, acc_fault,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata, acc_addr, acc_phys_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [5:0] udb_q;
  logic       wr_q;
  always_ff @(posedge clk)
    if (rst) {wr_q, udb_q} <= 7'h00;
    else if (clk_en && reg_wr && reg_addr == 8'h00) {wr_q, udb_q} <= {1'b1, reg_wdata[15:10]};
  sequence s_wr; reg_wr && reg_addr == 8'h00; endsequence
  sequence s_rd; reg_rd && reg_addr == 8'h00; endsequence
  field_keep_a: assert property (s_wr ##1 s_rd |=> reg_rdata[15:10] == $past(reg_wdata[15:10], 2))
    else $error("field lost");
  low_zero_a: assert property (s_rd |=> reg_rdata[9:0] == 10'h000) else $error("low bits set");
  high_zero_a: assert property (s_rd |=> reg_rdata[31:16] == 16'h0000) else $error("high set");
  rst_clear_a: assert property (reg_rd && reg_addr == 8'h00 && !wr_q |=> reg_rdata == 32'h0000_0000)
    else $error("not clear");
  cached_map_a: assert property (acc_valid && !acc_phys && acc_addr[31:29] == 3'h4 |=> acc_cacheable
    && acc_phys_addr == {3'h0, $past(acc_addr[28:0])}) else $error("cached map");
  phys_pass_a: assert property (acc_valid && acc_phys |=> acc_phys_addr == $past(acc_addr))
    else $error("phys map");
  user_seg_a: assert property (acc_valid && !acc_phys && !acc_addr[31] |=>
    acc_phys_addr == $past(acc_addr) + 32'h4000_0000) else $error("user map");
  user_fault_a: assert property (acc_valid && !acc_phys && acc_user_mode && acc_addr[31] |=> acc_fault)
    else $error("no fault");
  ram_split_a: assert property (acc_valid && acc_phys && acc_addr < RAM_SIZE |=> acc_in_ram &&
    acc_user_region == (udb_q != 6'h00 && $past(acc_addr) >= {16'h0000, udb_q, 10'h000}))
    else $error("split");
endmodule // rukp_chk
bind rukp_partition rukp_chk #(.RAM_SIZE(RAM_SIZE)) i_chk (
  .clk(clk), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .acc_valid(acc_valid), .acc_phys(acc_phys), .acc_user_mode(acc_user_mode),
  .acc_cacheable(acc_cacheable), .acc_in_ram(acc_in_ram), .acc_user_region(acc_user_region),
  .acc_fault(acc_fault), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .acc_addr(acc_addr), .acc_phys_addr(acc_phys_addr));
`default_nettype wire
